// ### design/intc_lvd.sv
// Interrupt flag and enable block with supply monitor control/status.
// Assumes a classic Wishbone master, asynchronous pin and comparator
// inputs, and peripheral event pulses on the system clock.
//
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module intc_lvd
	import intc_lvd_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// External interrupt pins, asynchronous
	input wire logic ext_irq_pin_a_i,
	input wire logic ext_irq_pin_b_i,
	// Peripheral event pulses, system clock
	input wire logic [NUM_SRC-1:0] periph_event_i,
	// Core power state, system clock
	input wire logic powered_down_i,
	// Analogue comparator result, asynchronous
	input wire logic supply_below_i,
	// Analogue monitor controls
	output logic supply_monitor_enable_o,
	output logic bandgap_output_enable_o,
	output logic reference_enable_o,
	output logic [2:0] threshold_select_o,
	// Core signalling
	output logic core_irq_o,
	output logic wake_o
);

	logic [7:0] regs_q [NUM_REGS];
	logic [7:0] hw_set [NUM_REGS];
	logic ack_q;
	logic [31:0] dat_q;
	logic req;
	logic [3:0] idx;
	logic addr_ok;
	logic wr_en;
	logic [7:0] rd_val;
	logic [1:0] pin_s1_q;
	logic [1:0] pin_s2_q;
	logic [1:0] pin_prev_q;
	logic [1:0] pin_event;
	logic cmp_s1_q;
	logic cmp_s2_q;
	logic low_supply_flag_q;
	logic [DLY_W-1:0] dly_cnt_q;
	logic mon_req_set;
	logic [3:0] mf_lvl;
	logic [3:0] mf_lvl_q;
	logic [3:0] mf_rise;
	logic [11:0] pend;
	logic irq_q;
	logic wake_q;
	logic mon_en_q;
	logic bg_en_q;
	logic ref_en_q;
	logic [2:0] thr_q;

	// Bus decode: one aligned word per register
	assign req = wb_cyc_i & wb_stb_i;
	assign idx = wb_adr_i[5:2];
	assign addr_ok = (wb_adr_i[1:0] == 2'b00) && (idx < 4'(NUM_REGS));
	assign wr_en = ack_q & req & wb_we_i & wb_sel_i[0] & addr_ok;

	// Read value; monitor flag replaces bit 5, upper bits stay zero
	always_comb
	begin
		rd_val = 8'h00;
		if (addr_ok)
		begin
			rd_val = regs_q[idx];
		end
		if (addr_ok && idx == IDX_LVC)
		begin
			rd_val[LVC_FLAG_BIT] = low_supply_flag_q;
			rd_val[7:6] = 2'b00;
		end
	end

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			dat_q <= (req & ~ack_q) ? {24'h00_0000, rd_val} : 32'h0000_0000;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// Pin synchronisers and edge detection
	generate
		for (genvar p = 0; p < 2; p++)
		begin : g_pin
			logic [1:0] sel;
			assign sel = (p == 0) ? regs_q[IDX_EDGE][EDGE_A_LSB +: 2]
				: regs_q[IDX_EDGE][EDGE_B_LSB +: 2];
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					pin_s1_q[p] <= 1'b0;
					pin_s2_q[p] <= 1'b0;
					pin_prev_q[p] <= 1'b0;
				end
				else
				begin
					pin_s1_q[p] <= (p == 0) ? ext_irq_pin_a_i : ext_irq_pin_b_i;
					pin_s2_q[p] <= pin_s1_q[p];
					pin_prev_q[p] <= pin_s2_q[p];
				end
			end
			// One pulse per selected edge
			assign pin_event[p] =
				((sel == EDGE_RISE || sel == EDGE_BOTH) && pin_s2_q[p] && !pin_prev_q[p]) ||
				((sel == EDGE_FALL || sel == EDGE_BOTH) && !pin_s2_q[p] && pin_prev_q[p]);
		end
	endgenerate

	// Comparator synchroniser and gated low supply flag
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cmp_s1_q <= 1'b0;
			cmp_s2_q <= 1'b0;
			low_supply_flag_q <= 1'b0;
		end
		else
		begin
			cmp_s1_q <= supply_below_i;
			cmp_s2_q <= cmp_s1_q;
			low_supply_flag_q <= cmp_s2_q & regs_q[IDX_LVC][LVC_EN_BIT];
		end
	end

	// Delay counter restarts on every drop of the flag
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !low_supply_flag_q)
		begin
			dly_cnt_q <= '0;
		end
		else if (dly_cnt_q != DLY_W'(MONITOR_INT_DELAY_CYC))
		begin
			dly_cnt_q <= dly_cnt_q + 1'b1;
		end
	end

	assign mon_req_set = low_supply_flag_q
		&& (dly_cnt_q == DLY_W'(MONITOR_INT_DELAY_CYC - 1));

	// Grouped request levels and their rising edges
	generate
		for (genvar m = 0; m < 4; m++)
		begin : g_group
			assign mf_lvl[m] = |(regs_q[5 + m][7:4] & regs_q[5 + m][3:0]);
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mf_lvl_q <= 4'h0;
		end
		else
		begin
			mf_lvl_q <= mf_lvl;
		end
	end

	assign mf_rise = mf_lvl & ~mf_lvl_q;

	// Hardware set events mapped onto flag bits
	always_comb
	begin
		for (int r = 0; r < NUM_REGS; r++)
		begin
			hw_set[r] = 8'h00;
		end
		hw_set[IDX_PRI0][6] = periph_event_i[SRC_TOUCH];
		hw_set[IDX_PRI0][5] = pin_event[1];
		hw_set[IDX_PRI0][4] = pin_event[0];
		hw_set[IDX_PRI1][7] = periph_event_i[SRC_ADC];
		hw_set[IDX_PRI1][6] = mf_rise[1];
		hw_set[IDX_PRI1][5] = mf_rise[0];
		hw_set[IDX_PRI1][4] = periph_event_i[SRC_UART];
		hw_set[IDX_PRI2][7] = mf_rise[3];
		hw_set[IDX_PRI2][6] = periph_event_i[SRC_TB1];
		hw_set[IDX_PRI2][5] = periph_event_i[SRC_TB0];
		hw_set[IDX_PRI2][4] = mf_rise[2];
		hw_set[IDX_MF0][5] = periph_event_i[SRC_CTM0A];
		hw_set[IDX_MF0][4] = periph_event_i[SRC_CTM0P];
		hw_set[IDX_MF1][7] = periph_event_i[SRC_STMA];
		hw_set[IDX_MF1][6] = periph_event_i[SRC_STMP];
		hw_set[IDX_MF1][5] = periph_event_i[SRC_CTM1A];
		hw_set[IDX_MF1][4] = periph_event_i[SRC_CTM1P];
		hw_set[IDX_MF2][6] = periph_event_i[SRC_SIM];
		hw_set[IDX_MF2][5] = periph_event_i[SRC_PTMA];
		hw_set[IDX_MF2][4] = periph_event_i[SRC_PTMP];
		hw_set[IDX_MF3][5] = periph_event_i[SRC_EEPROM];
		hw_set[IDX_MF3][4] = mon_req_set;
	end

	// Register file; writes merge with hardware sets, set wins
	generate
		for (genvar r = 0; r < NUM_REGS; r++)
		begin : g_reg
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					regs_q[r] <= REG_RESET;
				end
				else if (wr_en && idx == 4'(r))
				begin
					regs_q[r] <= (wb_dat_i[7:0] & WMASK[r]) | hw_set[r];
				end
				else
				begin
					regs_q[r] <= regs_q[r] | hw_set[r];
				end
			end
		end
	endgenerate

	// Primary pending requests: flag and its own enable
	assign pend[2:0] = regs_q[IDX_PRI0][6:4] & regs_q[IDX_PRI0][3:1];
	assign pend[3] = 1'b0;
	assign pend[7:4] = regs_q[IDX_PRI1][7:4] & regs_q[IDX_PRI1][3:0];
	assign pend[11:8] = regs_q[IDX_PRI2][7:4] & regs_q[IDX_PRI2][3:0];

	// Core request gated by the global enable; wake on a new monitor request
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_q <= 1'b0;
			wake_q <= 1'b0;
		end
		else
		begin
			irq_q <= regs_q[IDX_PRI0][GLOBAL_EN_BIT] & (|pend);
			wake_q <= powered_down_i & mon_req_set & ~regs_q[IDX_MF3][4]
				& regs_q[IDX_MF3][0];
		end
	end

	// Analogue controls, unaffected by the power state
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mon_en_q <= 1'b0;
			bg_en_q <= 1'b0;
			ref_en_q <= 1'b0;
			thr_q <= THR_2V0;
		end
		else
		begin
			mon_en_q <= regs_q[IDX_LVC][LVC_EN_BIT];
			bg_en_q <= regs_q[IDX_LVC][LVC_BG_BIT];
			ref_en_q <= regs_q[IDX_LVC][LVC_EN_BIT] | regs_q[IDX_LVC][LVC_BG_BIT];
			thr_q <= regs_q[IDX_LVC][LVC_THR_LSB +: 3];
		end
	end

	assign core_irq_o = irq_q;
	assign wake_o = wake_q;
	assign supply_monitor_enable_o = mon_en_q;
	assign bandgap_output_enable_o = bg_en_q;
	assign reference_enable_o = ref_en_q;
	assign threshold_select_o = thr_q;

	// Checks
	a_bus_ack_next: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !ack_q |=> ack_q ##1 !ack_q)
		else $error("ack not given one cycle after request");

	a_lvc_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !ack_q && wb_adr_i == OFS_LOW_VOLTAGE_CONTROL |=> wb_dat_o[7:6] == 2'b00)
		else $error("monitor control upper bits not zero");

	a_edge_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !ack_q && wb_adr_i == OFS_EXT_INT_EDGE_SELECT |=> wb_dat_o[7:4] == 4'h0)
		else $error("edge select upper bits not zero");

	a_pin_a_rise: assert property (@(posedge clk_i) disable iff (rst_i)
		regs_q[IDX_EDGE][1:0] == EDGE_RISE && pin_s2_q[0] && !pin_prev_q[0]
		|=> regs_q[IDX_PRI0][4])
		else $error("pin a rising edge did not set flag");

	a_pin_b_fall: assert property (@(posedge clk_i) disable iff (rst_i)
		regs_q[IDX_EDGE][3:2] == EDGE_RISE && !pin_s2_q[1] && pin_prev_q[1]
		|-> !pin_event[1])
		else $error("pin b falling edge taken under rising select");

	a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		regs_q[IDX_PRI0][4] && !(wr_en && idx == IDX_PRI0) |=> regs_q[IDX_PRI0][4])
		else $error("pin a flag lost without software clear");

	a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_en && idx == IDX_MF3 && hw_set[IDX_MF3] != 8'h00
		|=> (regs_q[IDX_MF3] & $past(hw_set[IDX_MF3])) == $past(hw_set[IDX_MF3]))
		else $error("hardware set lost to software clear");

	a_mon_req_delay: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(low_supply_flag_q) |-> !mon_req_set [*8])
		else $error("monitor request set before delay");

	a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		!regs_q[IDX_PRI0][GLOBAL_EN_BIT] |=> !core_irq_o)
		else $error("interrupt raised with global enable clear");

	a_ref_auto: assert property (@(posedge clk_i) disable iff (rst_i)
		regs_q[IDX_LVC][LVC_EN_BIT] |=> reference_enable_o)
		else $error("reference off while monitor enabled");

	a_flag_gated: assert property (@(posedge clk_i) disable iff (rst_i)
		!regs_q[IDX_LVC][LVC_EN_BIT] |=> !low_supply_flag_q)
		else $error("low flag set while monitor off");

	a_wake_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		wake_o |-> $past(powered_down_i) && $past(mon_req_set))
		else $error("wake without new monitor request");

	c_wake: cover property (@(posedge clk_i) disable iff (rst_i) wake_o);
	c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(core_irq_o));
	c_both_edges: cover property (@(posedge clk_i) disable iff (rst_i)
		regs_q[IDX_EDGE][1:0] == EDGE_BOTH && pin_event[0]);
	c_set_clash: cover property (@(posedge clk_i) disable iff (rst_i)
		wr_en && idx == IDX_MF3 && hw_set[IDX_MF3] != 8'h00);

endmodule // intc_lvd

// ### design/intc_lvd_pkg.sv
// Constants, register map and encodings of the interrupt flag block
// with its supply monitor. Shared by the block and its bench.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone bus.
package intc_lvd_pkg;

	// Register count and byte offsets, one aligned word each
	localparam int NUM_REGS = 9;
	localparam logic [5:0] OFS_LOW_VOLTAGE_CONTROL = 6'h00;
	localparam logic [5:0] OFS_EXT_INT_EDGE_SELECT = 6'h04;
	localparam logic [5:0] OFS_PRIMARY_INT_CTRL_0 = 6'h08;
	localparam logic [5:0] OFS_PRIMARY_INT_CTRL_1 = 6'h0c;
	localparam logic [5:0] OFS_PRIMARY_INT_CTRL_2 = 6'h10;
	localparam logic [5:0] OFS_MULTIFUNC_INT_CTRL_0 = 6'h14;
	localparam logic [5:0] OFS_MULTIFUNC_INT_CTRL_1 = 6'h18;
	localparam logic [5:0] OFS_MULTIFUNC_INT_CTRL_2 = 6'h1c;
	localparam logic [5:0] OFS_MULTIFUNC_INT_CTRL_3 = 6'h20;

	// Register indexes (byte offset divided by four)
	localparam logic [3:0] IDX_LVC = 4'h0;
	localparam logic [3:0] IDX_EDGE = 4'h1;
	localparam logic [3:0] IDX_PRI0 = 4'h2;
	localparam logic [3:0] IDX_PRI1 = 4'h3;
	localparam logic [3:0] IDX_PRI2 = 4'h4;
	localparam logic [3:0] IDX_MF0 = 4'h5;
	localparam logic [3:0] IDX_MF1 = 4'h6;
	localparam logic [3:0] IDX_MF2 = 4'h7;
	localparam logic [3:0] IDX_MF3 = 4'h8;

	// Reset value and software-writable bits of each register
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] WMASK [NUM_REGS] = '{8'h1f, 8'h0f, 8'h7f, 8'hff, 8'hff,
		8'h33, 8'hff, 8'h77, 8'h33};

	// Field positions in the monitor control, edge select and primary control 0 registers
	localparam int LVC_FLAG_BIT = 5;
	localparam int LVC_EN_BIT = 4;
	localparam int LVC_BG_BIT = 3;
	localparam int LVC_THR_LSB = 0;
	localparam int EDGE_A_LSB = 0;
	localparam int EDGE_B_LSB = 2;
	localparam int GLOBAL_EN_BIT = 0;

	// Threshold levels, 2.0 V up to 4.0 V
	typedef enum logic [2:0] {
		THR_2V0 = 3'b000, THR_2V2 = 3'b001, THR_2V4 = 3'b010, THR_2V7 = 3'b011,
		THR_3V0 = 3'b100, THR_3V3 = 3'b101, THR_3V6 = 3'b110, THR_4V0 = 3'b111
	} threshold_t;

	// Pin edge selection
	typedef enum logic [1:0] {
		EDGE_OFF = 2'b00, EDGE_RISE = 2'b01, EDGE_FALL = 2'b10, EDGE_BOTH = 2'b11
	} edge_sel_t;

	// Positions of the peripheral event pulses on the source vector
	localparam int NUM_SRC = 15;
	localparam int SRC_TOUCH = 0;
	localparam int SRC_UART = 1;
	localparam int SRC_ADC = 2;
	localparam int SRC_TB0 = 3;
	localparam int SRC_TB1 = 4;
	localparam int SRC_CTM0P = 5;
	localparam int SRC_CTM0A = 6;
	localparam int SRC_CTM1P = 7;
	localparam int SRC_CTM1A = 8;
	localparam int SRC_STMP = 9;
	localparam int SRC_STMA = 10;
	localparam int SRC_PTMP = 11;
	localparam int SRC_PTMA = 12;
	localparam int SRC_SIM = 13;
	localparam int SRC_EEPROM = 14;

	// Monitor interrupt delay and its cycle count
	localparam int CLK_PERIOD_NS = 10;
	localparam int MONITOR_INT_DELAY_NS = 1000;
	localparam int MONITOR_INT_DELAY_CYC = (MONITOR_INT_DELAY_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int DLY_W = 8;

endpackage

// ### tb/core_pins_model.sv
// Model of the core and the two interrupt pins facing the block.
// Assumes the bench calls its tasks from a process timed on clk_i.
`timescale 1ns/1ps
module core_pins_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// From the block
	input wire logic core_irq_i,
	input wire logic wake_i,
	// To the block
	output logic pin_a_o,
	output logic pin_b_o,
	output logic powered_down_o
);
	int wake_cnt = 0;
	logic sleep_req = 1'b0;
	// Quiet pins and an awake core at time zero
	initial
	begin
		pin_a_o = 1'b0;
		pin_b_o = 1'b0;
		powered_down_o = 1'b0;
	end
	// Pin levels change after an edge and hold long enough to be seen
	task automatic set_pins(input logic a, input logic b);
		@(posedge clk_i);
		pin_a_o <= a;
		pin_b_o <= b;
		repeat (6) @(posedge clk_i);
	endtask
	// Ask the core to enter sleep
	task automatic go_sleep();
		@(posedge clk_i);
		sleep_req <= 1'b1;
	endtask
	// Core leaves sleep on a wake pulse
	always @(posedge clk_i)
	begin
		if (rst_i)
			powered_down_o <= 1'b0;
		else if (wake_i)
		begin
			powered_down_o <= 1'b0;
			sleep_req <= 1'b0;
			wake_cnt <= wake_cnt + 1;
		end
		else if (sleep_req)
			powered_down_o <= 1'b1;
	end
endmodule // core_pins_model

// ### tb/intc_lvd_tb.sv
// Self-checking bench of the interrupt flag block and supply monitor.
// Assumes the core and pin model beside it and a 100 MHz clock.
`timescale 1ns/1ps
module intc_lvd_tb;
	import intc_lvd_pkg::*;
	localparam logic [3:0] SIDX [NUM_SRC] = '{IDX_PRI0, IDX_PRI1, IDX_PRI1, IDX_PRI2,
		IDX_PRI2, IDX_MF0, IDX_MF0, IDX_MF1, IDX_MF1, IDX_MF1, IDX_MF1, IDX_MF2,
		IDX_MF2, IDX_MF2, IDX_MF3};
	localparam int SBIT [NUM_SRC] = '{6, 4, 7, 5, 6, 4, 5, 4, 5, 6, 7, 4, 5, 6, 5};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [5:0] wb_adr_i = 6'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [NUM_SRC-1:0] periph_event_i = '0;
	logic supply_below_i = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, pin_a, pin_b, pdown, mon_en, bg_en, ref_en, core_irq, wake;
	logic [2:0] thr;
	logic [31:0] rd;
	int n_fail = 0;
	int n_tests = 0;
	int cyc_cnt = 0;
	// 100 MHz clock
	always #5 clk_i = ~clk_i;
	intc_lvd DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_irq_pin_a_i(pin_a),
		.ext_irq_pin_b_i(pin_b), .periph_event_i(periph_event_i), .powered_down_i(pdown),
		.supply_below_i(supply_below_i), .supply_monitor_enable_o(mon_en),
		.bandgap_output_enable_o(bg_en), .reference_enable_o(ref_en),
		.threshold_select_o(thr), .core_irq_o(core_irq), .wake_o(wake));
	core_pins_model core (.clk_i(clk_i), .rst_i(rst_i), .core_irq_i(core_irq),
		.wake_i(wake), .pin_a_o(pin_a), .pin_b_o(pin_b), .powered_down_o(pdown));
	// Verdict and end of run
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Compare a value seen at the ports
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Classic single Wishbone cycle, waits for ack
	task automatic wb(input logic we, input logic [3:0] idx, input logic [7:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {24'h0, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		repeat (2) @(posedge clk_i); // Registered outputs settle before the caller looks
	endtask
	// Read a register and compare
	task automatic rdc(input logic [3:0] idx, input logic [31:0] exp);
		wb(1'b0, idx, 8'h00);
		chk(rd, exp);
	endtask
	// Hang guard
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt > 20000)
		begin
			n_fail++;
			end_sim();
		end
	end
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values, unmapped place included
		for (int i = 0; i < 10; i++)
			rdc(4'(i), 32'h0);
		for (int i = 0; i < 10; i++)
			wb(1'b1, 4'(i), 8'hff);
		for (int i = 0; i < 10; i++)
			rdc(4'(i), i < 9 ? 32'(WMASK[i]) : 32'h0);
		chk(32'({thr, mon_en, bg_en, ref_en, core_irq}), 32'h7f);
		for (int i = 0; i < 9; i++)
			wb(1'b1, 4'(i), 8'h00);
		chk(32'({thr, mon_en, bg_en, ref_en, core_irq}), 32'h0);
		// Every threshold code, bandgap enable alternating
		for (int t = 0; t < 8; t++)
		begin
			wb(1'b1, IDX_LVC, {4'h0, t[0], t[2:0]});
			chk(32'({thr, mon_en, bg_en, ref_en}), 32'({t[2:0], 1'b0, t[0], t[0]}));
		end
		// Every edge mode, the two pins with different modes
		for (int m = 0; m < 4; m++)
		begin
			wb(1'b1, IDX_EDGE, 8'({2'(3 - m), 2'(m)}));
			core.set_pins(1'b1, 1'b1);
			rdc(IDX_PRI0, 32'({~m[0], m[0], 4'h0}));
			wb(1'b1, IDX_PRI0, 8'h00);
			core.set_pins(1'b0, 1'b0);
			rdc(IDX_PRI0, 32'({~m[1], m[1], 4'h0}));
			if (m < 3)
				wb(1'b1, IDX_PRI0, 8'h00);
		end
		// Pin a flag pending with global enable set: source enable gates the core request, clearing the flag drops it
		wb(1'b1, IDX_PRI0, 8'h11);
		chk(32'(core_irq), 32'h0);
		wb(1'b1, IDX_PRI0, 8'h13);
		chk(32'(core_irq), 32'h1);
		wb(1'b1, IDX_PRI0, 8'h01);
		chk(32'(core_irq), 32'h0);
		wb(1'b1, IDX_PRI0, 8'h00);
		// Each peripheral event lands in its own flag
		for (int s = 0; s < NUM_SRC; s++)
		begin
			@(posedge clk_i);
			periph_event_i <= NUM_SRC'(1) << s;
			@(posedge clk_i);
			periph_event_i <= '0;
			rdc(SIDX[s], 32'(1) << SBIT[s]);
			wb(1'b1, SIDX[s], 8'h00);
		end
		// Event held through a software clear of its flag: the set wins
		periph_event_i[SRC_EEPROM] <= 1'b1;
		wb(1'b1, IDX_MF3, 8'h00);
		periph_event_i <= '0;
		rdc(IDX_MF3, 32'h20);
		wb(1'b1, IDX_MF3, 8'h00);
		rdc(IDX_MF3, 32'h00);
		// Monitor in sleep, supply dips briefly then stays low
		wb(1'b1, IDX_MF3, 8'h01);
		wb(1'b1, IDX_LVC, 8'h15);
		core.go_sleep();
		repeat (4) @(posedge clk_i);
		supply_below_i <= 1'b1;
		repeat (60) @(posedge clk_i);
		supply_below_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		supply_below_i <= 1'b1;
		repeat (40) @(posedge clk_i);
		rdc(IDX_MF3, 32'h01);
		chk(32'(pdown), 32'h1);
		repeat (80) @(posedge clk_i);
		rdc(IDX_MF3, 32'h11);
		rdc(IDX_PRI2, 32'h80);
		rdc(IDX_LVC, 32'h35);
		chk(32'(core.wake_cnt), 32'h1);
		chk(32'(pdown), 32'h0);
		// Flag preset before sleep blocks the wake
		supply_below_i <= 1'b0;
		wb(1'b1, IDX_MF3, 8'h00);
		wb(1'b1, IDX_PRI2, 8'h00);
		wb(1'b1, IDX_MF3, 8'h11);
		core.go_sleep();
		@(posedge clk_i);
		supply_below_i <= 1'b1;
		repeat (130) @(posedge clk_i);
		chk(32'(core.wake_cnt), 32'h1);
		chk(32'(pdown), 32'h1);
		// Monitor switched off hides the low supply
		wb(1'b1, IDX_LVC, 8'h05);
		rdc(IDX_LVC, 32'h05);
		chk(32'({mon_en, ref_en}), 32'h0);
		end_sim();
	end
endmodule // intc_lvd_tb
